/* logic/uart_fmt_pkg.sv */
// Constants, types and helpers of the line format and modem control UART
package uart_fmt_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ          = 125_000_000;
  localparam int BAUD_RATE       = 115_200;
  localparam int HALF_BIT_CYCLES = CLK_HZ / (2 * BAUD_RATE);
  localparam int IR_PULSE_CYCLES = (2 * HALF_BIT_CYCLES * 3) / 16;

  // ----------------------------------------
  // Register map and reset values
  // ----------------------------------------
  localparam logic [7:0] OFF_LFC   = 8'h00;
  localparam logic [7:0] OFF_MLC   = 8'h04;
  localparam logic [7:0] OFF_ISTAT = 8'h08;
  localparam logic [7:0] OFF_ICLR  = 8'h0c;
  localparam logic [7:0] OFF_IEN   = 8'h10;
  localparam logic [7:0] OFF_MSTAT = 8'h14;
  localparam logic [7:0] OFF_DATA  = 8'h18;
  localparam logic [7:0] LFC_RESET = 8'h00;
  localparam logic [7:0] MLC_RESET = 8'h00;
  localparam logic [7:0] MLC_MASK  = 8'h5f;
  localparam logic [4:0] IEN_RESET = 5'h00;

  // Interrupt status bit positions
  localparam int EV_RX_READY = 0;
  localparam int EV_TX_DONE  = 1;
  localparam int EV_PAR_ERR  = 2;
  localparam int EV_FRM_ERR  = 3;
  localparam int EV_MODEM    = 4;
  localparam int EV_COUNT    = 5;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] spare;
    logic       parity_force_select;
    logic       parity_even_select;
    logic       parity_enable_bit;
    logic       stop_length_bit;
    logic [1:0] word_length_field;
  } line_format_type;

  typedef struct packed {
    logic spare7;
    logic infrared_route_enable;
    logic spare5;
    logic loopback_enable;
    logic aux_output_two_irq_enable;
    logic aux_output_one;
    logic request_to_send_bit;
    logic terminal_ready_bit;
  } modem_line_type;

  // Asserted-high view of the handshake inputs
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_sig_type;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
  } tx_state_type;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } rx_state_type;

  // Parity bit for the active data bits
  function automatic logic parity_of(input logic [7:0] d, input line_format_type f);
    logic [7:0] m;
    m = d & (8'hff >> (3 - f.word_length_field));
    case ({f.parity_force_select, f.parity_even_select})
      2'b00:   parity_of = ~^m;
      2'b01:   parity_of = ^m;
      2'b10:   parity_of = 1'b1;
      default: parity_of = 1'b0;
    endcase
  endfunction

endpackage

/* logic/uart_fmt_core.sv */
// UART with programmable line format, modem control, loop-back and infrared path
`timescale 1ns/10ps
`default_nettype none
module uart_fmt_core
  import uart_fmt_pkg::*;
#(
  parameter int HALF_BIT = HALF_BIT_CYCLES,
  parameter int IR_PULSE = IR_PULSE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             tx_o,
  input  wire logic        rx_i,
  output logic             rts_n,
  output logic             dtr_n,
  input  wire logic        cts_n_i,
  input  wire logic        dsr_n_i,
  input  wire logic        dcd_n_i,
  input  wire logic        ri_n_i,
  output logic             interrupt_output_pin,
  output logic             irq_oe_n
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (HALF_BIT < 4 || HALF_BIT > 32768 || IR_PULSE < 1 || IR_PULSE >= HALF_BIT) begin : g_bad
    $error("uart_fmt_core: HALF_BIT or IR_PULSE out of range");
  end

  localparam logic [15:0] HALF_LAST = 16'(HALF_BIT - 1);
  localparam logic [15:0] FULL_LAST = 16'(2 * HALF_BIT - 1);
  localparam logic [15:0] IR_LEN    = 16'(IR_PULSE);
  localparam logic [16:0] IR_HOLD   = 17'(2 * HALF_BIT);

  // ----------------------------------------
  // Registers and bus decode
  // ----------------------------------------
  line_format_type   lfc_r;
  modem_line_type    mlc_r;
  logic [EV_COUNT-1:0] ist_r;
  logic [EV_COUNT-1:0] ien_r;
  logic [EV_COUNT-1:0] ev;
  logic [7:0]        rx_buf_r;
  logic              setup;
  logic              wr;
  logic              mapped;
  logic              tx_busy;
  modem_sig_type     msig;
  modem_sig_type     msig_prev_r;

  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite;
  assign pready = 1'b1;
  assign mapped = paddr == OFF_LFC || paddr == OFF_MLC || paddr == OFF_ISTAT || paddr == OFF_ICLR
               || paddr == OFF_IEN || paddr == OFF_MSTAT || paddr == OFF_DATA;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfc_r <= LFC_RESET;
    end else if (wr && paddr == OFF_LFC) begin
      lfc_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mlc_r <= MLC_RESET;
    end else if (wr && paddr == OFF_MLC) begin
      mlc_r <= pwdata[7:0] & MLC_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ien_r <= IEN_RESET;
    end else if (wr && paddr == OFF_IEN) begin
      ien_r <= pwdata[EV_COUNT-1:0];
    end
  end

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ist_r <= '0;
    end else if (wr && paddr == OFF_ICLR) begin
      ist_r <= (ist_r & ~pwdata[EV_COUNT-1:0]) | ev;
    end else begin
      ist_r <= ist_r | ev;
    end
  end

  // Read data is captured in the setup cycle, so the access cycle never waits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~mapped;
      case (paddr)
        OFF_LFC:   prdata <= {24'h0, lfc_r};
        OFF_MLC:   prdata <= {24'h0, mlc_r};
        OFF_ISTAT: prdata <= {27'h0, ist_r};
        OFF_IEN:   prdata <= {27'h0, ien_r};
        OFF_MSTAT: prdata <= {27'h0, tx_busy, msig};
        OFF_DATA:  prdata <= {24'h0, rx_buf_r};
        default:   prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Modem lines
  // ----------------------------------------
  always_comb begin
    if (mlc_r.loopback_enable) begin
      msig.cts = mlc_r.request_to_send_bit;
      msig.dsr = mlc_r.terminal_ready_bit;
      msig.ri  = mlc_r.aux_output_one;
      msig.dcd = mlc_r.aux_output_two_irq_enable;
    end else begin
      msig.cts = ~cts_n_i;
      msig.dsr = ~dsr_n_i;
      msig.ri  = ~ri_n_i;
      msig.dcd = ~dcd_n_i;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msig_prev_r <= '0;
    end else begin
      msig_prev_r <= msig;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end else begin
      rts_n <= ~mlc_r.request_to_send_bit;
      dtr_n <= ~mlc_r.terminal_ready_bit;
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  tx_state_type tx_state_r;
  logic [15:0]  tx_cnt_r;
  logic [2:0]   tx_halves_r;
  logic [2:0]   tx_bits_r;
  logic [7:0]   tx_shift_r;
  logic         tx_par_r;
  logic         tx_tick;
  logic         tx_bit_end;
  logic [2:0]   stop_halves;
  logic         tx_ser;
  logic         tx_start;

  assign tx_busy  = tx_state_r != TX_IDLE;
  assign tx_start = wr && paddr == OFF_DATA && !tx_busy;
  assign tx_tick  = tx_busy && tx_cnt_r == HALF_LAST;
  // Five-bit words shorten the long stop to three half bits
  assign stop_halves = !lfc_r.stop_length_bit ? 3'd2 : (lfc_r.word_length_field == 2'b00 ? 3'd3 : 3'd4);
  assign tx_bit_end  = tx_tick && (tx_halves_r + 3'd1 == (tx_state_r == TX_STOP ? stop_halves : 3'd2));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_r    <= '0;
      tx_halves_r <= '0;
    end else if (tx_start || tx_tick) begin
      tx_cnt_r    <= '0;
      tx_halves_r <= tx_bit_end || tx_start ? 3'd0 : tx_halves_r + 3'd1;
    end else if (tx_busy) begin
      tx_cnt_r <= tx_cnt_r + 16'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_r <= TX_IDLE;
      tx_bits_r  <= '0;
      tx_shift_r <= '0;
      tx_par_r   <= 1'b0;
    end else begin
      case (tx_state_r)
        TX_IDLE: begin
          if (tx_start) begin
            tx_state_r <= TX_START;
            tx_shift_r <= pwdata[7:0];
            tx_par_r   <= parity_of(pwdata[7:0], lfc_r);
            tx_bits_r  <= '0;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_state_r <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_shift_r <= tx_shift_r >> 1;
            tx_bits_r  <= tx_bits_r + 3'd1;
            if (tx_bits_r == {1'b1, lfc_r.word_length_field}) begin
              tx_state_r <= lfc_r.parity_enable_bit ? TX_PAR : TX_STOP;
            end
          end
        end
        TX_PAR: begin
          if (tx_bit_end) begin
            tx_state_r <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_bit_end) begin
            tx_state_r <= TX_IDLE;
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  always_comb begin
    case (tx_state_r)
      TX_START: tx_ser = 1'b0;
      TX_DATA:  tx_ser = tx_shift_r[0];
      TX_PAR:   tx_ser = tx_par_r;
      default:  tx_ser = 1'b1;
    endcase
  end

  // Infrared encoder: short high pulse at the head of each zero bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_o <= 1'b1;
    end else if (mlc_r.loopback_enable) begin
      tx_o <= 1'b1;
    end else if (mlc_r.infrared_route_enable) begin
      tx_o <= !tx_ser && tx_halves_r == 3'd0 && tx_cnt_r < IR_LEN;
    end else begin
      tx_o <= tx_ser;
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  rx_state_type rx_state_r;
  logic [15:0]  rx_cnt_r;
  logic [2:0]   rx_bits_r;
  logic [7:0]   rx_data_r;
  logic [16:0]  ir_hold_r;
  logic         rx_ext;
  logic         rx_line;
  logic         rx_hit;
  logic         rx_par_bad;

  // Infrared decoder: each pulse stretches to one low bit time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_hold_r <= '0;
    end else if (rx_i) begin
      ir_hold_r <= IR_HOLD;
    end else if (ir_hold_r != '0) begin
      ir_hold_r <= ir_hold_r - 17'd1;
    end
  end

  assign rx_ext  = mlc_r.infrared_route_enable ? ir_hold_r == '0 : rx_i;
  assign rx_line = mlc_r.loopback_enable ? tx_ser : rx_ext;
  assign rx_hit  = rx_cnt_r == (rx_state_r == RX_START ? HALF_LAST : FULL_LAST);
  assign rx_par_bad = rx_line != parity_of(rx_data_r, lfc_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_r <= '0;
    end else if (rx_state_r == RX_IDLE || rx_hit) begin
      rx_cnt_r <= '0;
    end else begin
      rx_cnt_r <= rx_cnt_r + 16'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_r <= RX_IDLE;
      rx_bits_r  <= '0;
      rx_data_r  <= '0;
      rx_buf_r   <= '0;
    end else begin
      case (rx_state_r)
        RX_IDLE: begin
          if (!rx_line) begin
            rx_state_r <= RX_START;
            rx_data_r  <= '0;
            rx_bits_r  <= '0;
          end
        end
        RX_START: begin
          if (rx_hit) begin
            rx_state_r <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_hit) begin
            rx_data_r[rx_bits_r] <= rx_line;
            rx_bits_r <= rx_bits_r + 3'd1;
            if (rx_bits_r == {1'b1, lfc_r.word_length_field}) begin
              rx_state_r <= lfc_r.parity_enable_bit ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_hit) begin
            rx_state_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_hit) begin
            rx_buf_r   <= rx_data_r;
            rx_state_r <= RX_IDLE;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Events and interrupt pin
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev <= '0;
    end else begin
      ev[EV_RX_READY] <= rx_state_r == RX_STOP && rx_hit;
      ev[EV_TX_DONE]  <= tx_state_r == TX_STOP && tx_bit_end;
      ev[EV_PAR_ERR]  <= rx_state_r == RX_PAR && rx_hit && rx_par_bad;
      ev[EV_FRM_ERR]  <= rx_state_r == RX_STOP && rx_hit && !rx_line;
      ev[EV_MODEM]    <= msig != msig_prev_r;
    end
  end

  // Enables gate every source whatever the loop-back setting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_output_pin <= 1'b0;
      irq_oe_n             <= 1'b1;
    end else begin
      interrupt_output_pin <= |(ist_r & ien_r);
      irq_oe_n             <= ~mlc_r.aux_output_two_irq_enable;
    end
  end

endmodule
`default_nettype wire

/* tb/uart_fmt_checker.sv */
// Port-level assertions for the UART core
`timescale 1ns/10ps
`default_nettype none
module uart_fmt_checker
  import uart_fmt_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        tx_o,
  input wire logic        rx_i,
  input wire logic        rts_n,
  input wire logic        dtr_n,
  input wire logic        cts_n_i,
  input wire logic        dsr_n_i,
  input wire logic        dcd_n_i,
  input wire logic        ri_n_i,
  input wire logic        interrupt_output_pin,
  input wire logic        irq_oe_n
);
  // ----
  // Register shadows
  // ----
  logic [7:0] mlc_r;
  logic [7:0] lfc_r;
  logic [1:0] age_r;
  logic       wr_now;
  logic       bad_adr;
  assign wr_now  = psel && penable && pwrite;
  assign bad_adr = paddr > OFF_DATA || paddr[1:0] != 2'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mlc_r <= 8'h00;
      lfc_r <= 8'h00;
    end else if (wr_now) begin
      if (paddr == OFF_MLC) mlc_r <= pwdata[7:0] & MLC_MASK;
      if (paddr == OFF_LFC) lfc_r <= pwdata[7:0];
    end
  end
  // Pins are flops behind the register, so allow settling edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) age_r <= 2'h3;
    else if (wr_now && paddr == OFF_MLC) age_r <= 2'h0;
    else if (age_r != 2'h3) age_r <= age_r + 2'h1;
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_read(a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  bus_err_a: assert property (apb_setup ##1 (psel && penable) |-> pslverr == bad_adr)
    else $error("slave error wrong");
  mlc_read_a: assert property (apb_setup ##1 apb_read(OFF_MLC) |-> prdata == {24'h0, mlc_r})
    else $error("modem reg readback wrong");
  lfc_read_a: assert property (apb_setup ##1 apb_read(OFF_LFC) |-> prdata == {24'h0, lfc_r})
    else $error("format reg readback wrong");
  rts_level_a: assert property (age_r == 2'h3 |-> rts_n == !mlc_r[1])
    else $error("rts pin wrong");
  dtr_level_a: assert property (age_r == 2'h3 |-> dtr_n == !mlc_r[0])
    else $error("dtr pin wrong");
  irq_oe_a: assert property (age_r == 2'h3 |-> irq_oe_n == !mlc_r[3])
    else $error("irq enable wrong");
  loop_tx_a: assert property (age_r == 2'h3 && mlc_r[4] |-> tx_o)
    else $error("tx not idle in loop");
  reset_val_a: assert property ($rose(rst_n) |-> tx_o && rts_n && irq_oe_n && !interrupt_output_pin)
    else $error("reset values wrong");
endmodule
bind uart_fmt_core uart_fmt_checker chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .tx_o(tx_o), .rx_i(rx_i), .rts_n(rts_n), .dtr_n(dtr_n), .cts_n_i(cts_n_i),
  .dsr_n_i(dsr_n_i), .dcd_n_i(dcd_n_i), .ri_n_i(ri_n_i),
  .interrupt_output_pin(interrupt_output_pin), .irq_oe_n(irq_oe_n));
`default_nettype wire

/* tb/uart_peer.sv */
// Remote serial peer on the receive and handshake pins
`timescale 1ns/10ps
`default_nettype none
module uart_peer #(
  parameter int HB  = 8,
  parameter int IRP = 3
) (
  input  wire logic       clk,
  input  wire logic       ir,
  input  wire logic [3:0] hs,
  output logic            rx_o,
  output logic            cts_n,
  output logic            dsr_n,
  output logic            dcd_n,
  output logic            ri_n
);
  logic busy = 1'b0;
  logic lvl  = 1'b1;
  // Idle line is mark; infrared idles dark
  assign rx_o  = busy ? lvl : !ir;
  assign cts_n = !hs[0];
  assign dsr_n = !hs[1];
  assign ri_n  = !hs[2];
  assign dcd_n = !hs[3];
  // One frame, parity below zero means none
  task automatic send(input int n, input logic [7:0] d, input int p);
    int b[$];
    b.push_back(0);
    for (int i = 0; i < n; i++) b.push_back(d[i]);
    if (p >= 0) b.push_back(p);
    b.push_back(1);
    foreach (b[i]) for (int c = 0; c < 2 * HB; c++) begin
      @(posedge clk);
      busy <= 1'b1;
      lvl  <= ir ? (b[i] == 0 && c < IRP) : b[i][0];
    end
    @(posedge clk);
    busy <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the UART core
`timescale 1ns/10ps
`default_nettype none
module tb
  import uart_fmt_pkg::*;
;
  localparam int HB  = 8;
  localparam int IRP = 3;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ir = 0, er;
  logic [7:0]  paddr = 0, d;
  logic [31:0] pwdata = 0, prdata, rd, rs = 24181;
  logic        pready, pslverr, tx_o, rx_i, rts_n, dtr_n, irq, irq_oe_n, cts_n, dsr_n, dcd_n, ri_n;
  logic [3:0]  hs = 0;
  int          n_errors = 0, checks = 0, lfc_m = 0, mlc_m = 0;
  always #4 clk = ~clk;
  uart_fmt_core #(.HALF_BIT(HB), .IR_PULSE(IRP)) dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .tx_o(tx_o), .rx_i(rx_i),
    .rts_n(rts_n), .dtr_n(dtr_n), .cts_n_i(cts_n), .dsr_n_i(dsr_n), .dcd_n_i(dcd_n), .ri_n_i(ri_n),
    .interrupt_output_pin(irq), .irq_oe_n(irq_oe_n));
  uart_peer #(.HB(HB), .IRP(IRP)) peer (
    .clk(clk), .ir(ir), .hs(hs), .rx_o(rx_i), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 64) begin
      chk(0, 1);
      finish_test();
    end
    if (w && a == OFF_LFC) lfc_m = wd;
    if (w && a == OFF_MLC) mlc_m = wd;
  endtask
  // Transmit one char, record the line until tx done raises the irq
  task automatic tx_run(input logic [7:0] c);
    logic q[$];
    int e[$];
    int n, s, ones, z, sc, len;
    n = 5 + lfc_m[1:0];
    ones = 0;
    e.push_back(0);
    for (int i = 0; i < n; i++) e.push_back(c[i]);
    for (int i = 0; i < n; i++) ones += c[i];
    if (lfc_m[3]) e.push_back(lfc_m[5] ? !lfc_m[4] : (lfc_m[4] ? ones % 2 : !(ones % 2)));
    sc = !lfc_m[2] ? 2 * HB : (n == 5 ? 3 * HB : 4 * HB);
    apb(1, OFF_ICLR, 32'h1f);
    apb(1, OFF_IEN, 32'h02);
    apb(1, OFF_DATA, c);
    do begin
      @(posedge clk);
      q.push_back(tx_o);
    end while (irq !== 1'b1 && q.size() < 900);
    if (q.size() >= 900) begin
      chk(0, 1);
      finish_test();
    end
    s = 0;
    while (s < q.size() - 1 && q[s] !== 1'b0) s++;
    ones = 0;
    z = 0;
    foreach (q[i]) ones += q[i];
    foreach (e[i]) z += (e[i] == 0);
    len = q.size() - s;
    if (mlc_m[4]) chk(ones, q.size());
    else if (mlc_m[6]) chk(ones, z * IRP);
    else begin
      foreach (e[i]) chk(q[s + HB + 2 * HB * i], e[i]);
      chk(len >= e.size() * 2 * HB + sc && len <= e.size() * 2 * HB + sc + 4, 1);
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, OFF_LFC, 0);
    chk(rd, 0);
    apb(0, OFF_MLC, 0);
    chk(rd, 0);
    apb(0, 8'h1c, 0);
    chk(rd, 0);
    chk(er, 1);
    $display("test reset done");
    for (int i = 0; i < 64; i++) begin
      apb(1, OFF_LFC, i);
      tx_run(8'(xs()));
    end
    $display("test transmit formats done");
    for (int w = 0; w < 4; w++) begin
      apb(1, OFF_LFC, w);
      d = 8'(xs());
      peer.send(5 + w, d, -1);
      apb(0, OFF_DATA, 0);
      chk(rd, d & (8'hff >> (3 - w)));
    end
    apb(1, OFF_LFC, 32'h1b);
    apb(1, OFF_ICLR, 32'h1f);
    peer.send(8, d, ^d);
    apb(0, OFF_ISTAT, 0);
    chk(rd[2:0], 3'h1);
    peer.send(8, d, !(^d));
    apb(0, OFF_ISTAT, 0);
    chk(rd[2], 1);
    $display("test receive done");
    apb(1, OFF_IEN, 0);
    for (int v = 0; v < 16; v++) begin
      hs <= 4'(v);
      repeat (4) @(posedge clk);
      apb(0, OFF_MSTAT, 0);
      chk(rd[3:0], v);
    end
    chk(irq, 0);
    for (int v = 0; v < 16; v++) begin
      hs <= 4'(xs());
      apb(1, OFF_MLC, 32'h10 | v);
      repeat (4) @(posedge clk);
      apb(0, OFF_MSTAT, 0);
      chk(rd[3:0], {v[3], v[2], v[0], v[1]});
      chk(rts_n, !v[1]);
      chk(irq_oe_n, !v[3]);
    end
    apb(1, OFF_ICLR, 32'h1f);
    apb(1, OFF_MLC, 32'h11);
    repeat (3) @(posedge clk);
    chk(irq, 0);
    apb(1, OFF_IEN, 32'h10);
    repeat (3) @(posedge clk);
    chk(irq, 1);
    apb(1, OFF_LFC, 32'h03);
    d = 8'(xs());
    tx_run(d);
    apb(0, OFF_DATA, 0);
    chk(rd, d);
    $display("test loopback done");
    apb(1, OFF_MLC, 32'h40);
    ir <= 1'b1;
    repeat (4) @(posedge clk);
    chk(tx_o, 0);
    tx_run(8'(xs()));
    d = 8'(xs());
    peer.send(8, d, -1);
    apb(0, OFF_DATA, 0);
    chk(rd, d);
    $display("test infrared done");
    finish_test();
  end
endmodule
`default_nettype wire
